/* src/pcr_pkg.sv */
/*
 Shared definitions for the privilege call and return sequencer: level
 encoding, command and gate-type codes, data widths and memory widths.
 Assumes one core clock and an external memory that holds the stacks,
 the gate descriptors and the task state segment.
*/
package pcr_pkg;
   localparam int PCR_AW = 64;
   localparam int PCR_SELW = 16;
   localparam int PCR_DISPW = 32;
   localparam logic [1:0] PCR_PL_MOST = 2'h0;
   localparam logic [1:0] PCR_PL_LEAST = 2'h3;
   localparam logic [63:0] PCR_WORD8 = 64'h0000_0000_0000_0008;
   localparam logic [63:0] PCR_WORD4 = 64'h0000_0000_0000_0004;
   localparam logic [63:0] PCR_MASK32 = 64'h0000_0000_FFFF_FFFF;
   localparam logic [3:0] PCR_GATE_CALL32 = 4'hC;
   localparam logic [4:0] PCR_PCOUNT_W = 5'h1F;
   localparam logic [7:0] PCR_TSS_SS_OFF = 8'h08;
   localparam logic [7:0] PCR_TSS_SP_OFF = 8'h04;
   localparam logic [7:0] PCR_TSS_STRIDE = 8'h08;

   typedef enum logic [2:0] {
      PCR_CMD_NONE = 3'h0,
      PCR_CMD_FAR_CALL = 3'h1,
      PCR_CMD_FAR_RET = 3'h2,
      PCR_CMD_NEAR = 3'h3,
      PCR_CMD_DIRECT_FAR = 3'h4,
      PCR_CMD_FAST_ENTRY = 3'h5,
      PCR_CMD_FAST_EXIT = 3'h6,
      PCR_CMD_LEGACY_FAST = 3'h7
   } pcr_cmd_t;

   typedef enum logic [1:0] {
      PCR_MEM_NONE = 2'h0,
      PCR_MEM_READ = 2'h1,
      PCR_MEM_WRITE = 2'h2
   } pcr_mem_t;
endpackage

/* src/pcr_priv_check.sv */
/*
 Combinational privilege check for a far transfer through a call gate.
 Assumes the gate fields are already fetched from memory.
*/
module pcr_priv_check
   import pcr_pkg::*;
(
   input wire logic [1:0] cur_pl,
   input wire logic [1:0] rpl,
   input wire logic [1:0] gate_dpl,
   input wire logic [1:0] target_dpl,
   input wire logic gate_present,
   input wire logic is_gate,
   input wire logic is_return,
   output logic ok,
   output logic raise_pl
);
   wire logic eff_ok;
   wire logic target_ok;
   // Lower number is more privileged, so access needs max(cpl,rpl) <= dpl.
   assign eff_ok = (cur_pl <= gate_dpl) && (rpl <= gate_dpl);
   assign target_ok = (target_dpl <= cur_pl);
   // Inward moves need a present gate and enough rights.
   assign raise_pl = is_return ? (rpl > cur_pl) : (target_dpl < cur_pl);
   assign ok = is_return ? (rpl >= cur_pl)
             : (is_gate && gate_present && eff_ok && target_ok);
endmodule

/* src/pcr_sp_adjust.sv */
/*
 Stack pointer step unit: push, pop and release, sized by mode.
 Assumes the caller holds the operand and only needs the new pointer.
*/
module pcr_sp_adjust
   import pcr_pkg::*;
(
   input wire logic [63:0] sp_in,
   input wire logic [63:0] amount,
   input wire logic down,
   input wire logic long_mode,
   output logic [63:0] sp_out
);
   wire logic [63:0] raw;
   assign raw = down ? (sp_in - amount) : (sp_in + amount);
   // Legacy stacks wrap at 4 GiB; long mode keeps the full width.
   assign sp_out = long_mode ? raw : (raw & PCR_MASK32);
endmodule

/* src/pcr_seq.sv */
/*
 Sequencer for far calls and returns across privilege levels through
 call gates, with stack switching via the task state segment and the
 branch sizing of 64-bit mode.
 Assumes a single-word memory port that answers each request with a
 one-cycle mem_ack; the decoder presents one command at a time with start.
*/
module pcr_seq
   import pcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [2:0] cmd,
   input wire logic long_mode,
   input wire logic addr_prefix,
   input wire logic [15:0] instr_sel,
   input wire logic [63:0] instr_off,
   input wire logic [31:0] disp,
   input wire logic [15:0] ret_n,
   input wire logic [63:0] tss_base,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_ack,
   output logic [1:0] mem_op,
   output logic [63:0] mem_addr,
   output logic [63:0] mem_wdata,
   output logic [15:0] code_selector_reg,
   output logic [63:0] instr_pointer_reg,
   output logic [15:0] stack_selector_reg,
   output logic [63:0] stack_pointer_reg,
   output logic [1:0] cur_pl_reg,
   output logic [63:0] count_mask_reg,
   output logic protection_fault,
   output logic done,
   output logic busy
);
   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_GATE0 = 4'h1, ST_GATE1 = 4'h3, ST_CHECK = 4'h2,
      ST_TSS_SP = 4'h6, ST_TSS_SS = 4'h7, ST_PUSH_SS = 4'h5, ST_PUSH_SP = 4'h4,
      ST_CP_RD = 4'hC, ST_CP_WR = 4'hD, ST_PUSH_CS = 4'hF, ST_PUSH_IP = 4'hE,
      ST_POP_IP = 4'hA, ST_POP_CS = 4'hB, ST_POP_SP = 4'h9, ST_POP_SS = 4'h8
   } pcr_st_t;
   pcr_st_t st_reg, st_next;
   logic [15:0] h_ss_reg, h_cs_reg, g_sel_reg;
   logic [63:0] h_sp_reg, h_ip_reg, g_off_reg, tmp_reg, new_sp_reg, sp_sel_reg;
   logic [4:0] g_cnt_reg, cnt_reg;
   logic [1:0] g_dpl_reg, tdpl_reg;
   logic g_pres_reg, g_is_gate_reg, ret_reg;
   logic [15:0] new_ss_reg;
   // ************************************************************
   // Decode
   // ************************************************************
   wire logic [63:0] wsz;
   wire logic [63:0] sp_dn, sp_up, rel_up;
   wire logic chk_ok, inward;
   wire logic [63:0] gate_addr;
   wire logic [63:0] tss_sp_addr;
   wire logic [63:0] disp_ext;
   wire logic [63:0] near_target;
   wire logic bad_cmd;
   assign wsz = long_mode ? PCR_WORD8 : PCR_WORD4;
   assign disp_ext = {{32{disp[31]}}, disp};
   assign near_target = long_mode ? instr_pointer_reg + disp_ext
                      : (instr_pointer_reg + disp_ext) & PCR_MASK32;
   // Long-mode gates fill two slots, so the index is scaled by sixteen there.
   assign gate_addr = {48'h0000_0000_0000, instr_sel[15:3], 3'h0} << (long_mode ? 1 : 0);
   assign tss_sp_addr = tss_base + 64'(PCR_TSS_SP_OFF) + 64'(PCR_TSS_STRIDE) * 64'(tdpl_reg);
   // Direct far forms in long mode, and fast entry or exit outside long mode, are refused outright.
   assign bad_cmd = (cmd == PCR_CMD_DIRECT_FAR && long_mode)
                  || ((cmd == PCR_CMD_FAST_ENTRY || cmd == PCR_CMD_FAST_EXIT)
                      && !long_mode);
   pcr_sp_adjust u_dn (.sp_in(stack_pointer_reg), .amount(wsz), .down(1'b1),
      .long_mode(long_mode), .sp_out(sp_dn));
   pcr_sp_adjust u_up (.sp_in(stack_pointer_reg), .amount(wsz), .down(1'b0),
      .long_mode(long_mode), .sp_out(sp_up));
   pcr_sp_adjust u_rel (.sp_in(stack_pointer_reg), .amount({48'h0000_0000_0000, ret_n}),
      .down(1'b0), .long_mode(long_mode), .sp_out(rel_up));
   pcr_priv_check u_chk (.cur_pl(cur_pl_reg), .rpl(ret_reg ? tmp_reg[1:0] : instr_sel[1:0]),
      .gate_dpl(g_dpl_reg), .target_dpl(tdpl_reg), .gate_present(g_pres_reg),
      .is_gate(g_is_gate_reg), .is_return(ret_reg), .ok(chk_ok), .raise_pl(inward));
   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ST_IDLE: if (start && !bad_cmd && cmd == PCR_CMD_FAR_CALL) st_next = ST_GATE0;
            else if (start && !bad_cmd && cmd == PCR_CMD_FAR_RET) st_next = ST_POP_IP;
         ST_GATE0: if (mem_ack) st_next = ST_GATE1;
         ST_GATE1: if (mem_ack) st_next = ST_CHECK;
         ST_CHECK: st_next = !chk_ok ? ST_IDLE : (inward ? ST_TSS_SP : ST_PUSH_CS);
         ST_TSS_SP: if (mem_ack) st_next = ST_TSS_SS;
         ST_TSS_SS: if (mem_ack) st_next = ST_PUSH_SS;
         ST_PUSH_SS: if (mem_ack) st_next = ST_PUSH_SP;
         ST_PUSH_SP: if (mem_ack) st_next = (g_cnt_reg != 5'h00) ? ST_CP_RD : ST_PUSH_CS;
         ST_CP_RD: if (mem_ack) st_next = ST_CP_WR;
         ST_CP_WR: if (mem_ack) st_next = (cnt_reg == 5'h01) ? ST_PUSH_CS : ST_CP_RD;
         ST_PUSH_CS: if (mem_ack) st_next = ST_PUSH_IP;
         ST_PUSH_IP: if (mem_ack) st_next = ST_IDLE;
         ST_POP_IP: if (mem_ack) st_next = ST_POP_CS;
         ST_POP_CS: if (mem_ack) st_next = ST_CHECK;
         ST_POP_SP: if (mem_ack) st_next = ST_POP_SS;
         ST_POP_SS: if (mem_ack) st_next = ST_IDLE;
      endcase
      if (st_reg == ST_CHECK && ret_reg && chk_ok)
         st_next = inward ? ST_POP_SP : ST_IDLE;
   end
   // ************************************************************
   // Memory port
   // ************************************************************
   always_comb begin
      mem_op = PCR_MEM_NONE;
      mem_addr = stack_pointer_reg;
      mem_wdata = 64'h0000_0000_0000_0000;
      unique case (st_reg)
         ST_GATE0: begin mem_op = PCR_MEM_READ; mem_addr = gate_addr; end
         ST_GATE1: begin mem_op = PCR_MEM_READ; mem_addr = gate_addr + PCR_WORD8; end
         ST_TSS_SP: begin mem_op = PCR_MEM_READ; mem_addr = tss_sp_addr; end
         ST_TSS_SS: begin mem_op = PCR_MEM_READ; mem_addr = tss_sp_addr + 64'(PCR_TSS_SS_OFF); end
         ST_PUSH_SS: begin mem_op = PCR_MEM_WRITE; mem_addr = sp_dn;
            mem_wdata = {48'h0000_0000_0000, h_ss_reg}; end
         ST_PUSH_SP: begin mem_op = PCR_MEM_WRITE; mem_addr = sp_dn; mem_wdata = h_sp_reg; end
         ST_CP_RD: begin mem_op = PCR_MEM_READ; mem_addr = sp_sel_reg; end
         ST_CP_WR: begin mem_op = PCR_MEM_WRITE; mem_addr = sp_dn; mem_wdata = tmp_reg; end
         ST_PUSH_CS: begin mem_op = PCR_MEM_WRITE; mem_addr = sp_dn;
            mem_wdata = {48'h0000_0000_0000, h_cs_reg}; end
         ST_PUSH_IP: begin mem_op = PCR_MEM_WRITE; mem_addr = sp_dn; mem_wdata = h_ip_reg; end
         ST_POP_IP, ST_POP_CS, ST_POP_SP, ST_POP_SS: mem_op = PCR_MEM_READ;
         default: ;
      endcase
   end
   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;
         cur_pl_reg <= PCR_PL_LEAST;
         {code_selector_reg, stack_selector_reg, h_ss_reg, h_cs_reg, g_sel_reg, new_ss_reg} <= '0;
         {instr_pointer_reg, stack_pointer_reg, h_sp_reg, h_ip_reg, g_off_reg} <= '0;
         {tmp_reg, new_sp_reg, sp_sel_reg} <= '0;
         count_mask_reg <= 64'hFFFF_FFFF_FFFF_FFFF;
         {g_cnt_reg, cnt_reg, g_dpl_reg, tdpl_reg, g_pres_reg, g_is_gate_reg, ret_reg} <= '0;
         {protection_fault, done, busy} <= '0;
      end else begin
         st_reg <= st_next;
         protection_fault <= 1'b0;
         done <= 1'b0;
         busy <= (st_next != ST_IDLE);
         if (st_reg == ST_IDLE && start) begin
            ret_reg <= (cmd == PCR_CMD_FAR_RET);
            // Count width follows the address size, not the operand size.
            count_mask_reg <= (long_mode && !addr_prefix) ? 64'hFFFF_FFFF_FFFF_FFFF
                              : PCR_MASK32;
            h_ss_reg <= stack_selector_reg;
            h_sp_reg <= stack_pointer_reg;
            h_cs_reg <= code_selector_reg;
            h_ip_reg <= instr_pointer_reg;
            // A refused command answers with the fault pulse alone; only ret_reg, count_mask_reg and the held copies change.
            protection_fault <= bad_cmd;
            if (cmd == PCR_CMD_NEAR) begin
               instr_pointer_reg <= near_target;
               done <= 1'b1;
            end
         end
         if (st_reg == ST_GATE0 && mem_ack) begin
            g_off_reg <= {48'h0000_0000_0000, mem_rdata[63:48]} << 16 | {48'h0, mem_rdata[15:0]};
            g_sel_reg <= mem_rdata[31:16];
            g_cnt_reg <= mem_rdata[36:32] & PCR_PCOUNT_W;
            g_is_gate_reg <= (mem_rdata[43:40] == PCR_GATE_CALL32);
            g_dpl_reg <= mem_rdata[46:45];
            g_pres_reg <= mem_rdata[47];
            tdpl_reg <= mem_rdata[17:16];
         end
         if (st_reg == ST_GATE1 && mem_ack && long_mode)
            g_off_reg[63:32] <= mem_rdata[31:0];
         // On returns the pops move stack_pointer_reg before this state, so a failed check restores it from h_sp_reg.
         if (st_reg == ST_CHECK) begin
            protection_fault <= !chk_ok;
            if (!chk_ok) begin
               stack_pointer_reg <= h_sp_reg;
               done <= 1'b1;
            end
            if (ret_reg && chk_ok) begin
               code_selector_reg <= tmp_reg[15:0];
               instr_pointer_reg <= h_ip_reg;
               stack_pointer_reg <= rel_up;
               if (!inward) done <= 1'b1;
            end
         end
         if (st_reg == ST_TSS_SP && mem_ack) new_sp_reg <= mem_rdata;
         if (st_reg == ST_TSS_SS && mem_ack) begin
            stack_selector_reg <= mem_rdata[15:0];
            stack_pointer_reg <= new_sp_reg;
            // Copying starts at the deepest parameter so the new frame keeps the caller's order.
            sp_sel_reg <= h_sp_reg + wsz * 64'(g_cnt_reg) - wsz;
            cnt_reg <= g_cnt_reg;
         end
         if ((st_reg == ST_PUSH_SS || st_reg == ST_PUSH_SP || st_reg == ST_CP_WR
              || st_reg == ST_PUSH_CS || st_reg == ST_PUSH_IP) && mem_ack)
            stack_pointer_reg <= sp_dn;
         if (st_reg == ST_CP_RD && mem_ack) tmp_reg <= mem_rdata;
         if (st_reg == ST_CP_WR && mem_ack) begin
            cnt_reg <= cnt_reg - 5'h01;
            sp_sel_reg <= sp_sel_reg - wsz;
         end
         if (st_reg == ST_PUSH_IP && mem_ack) begin
            code_selector_reg <= g_sel_reg;
            instr_pointer_reg <= g_off_reg;
            cur_pl_reg <= tdpl_reg < cur_pl_reg ? tdpl_reg : cur_pl_reg;
            done <= 1'b1;
         end
         if (st_reg == ST_POP_IP && mem_ack) begin
            h_ip_reg <= mem_rdata;
            stack_pointer_reg <= sp_up;
         end
         if (st_reg == ST_POP_CS && mem_ack) begin
            tmp_reg <= mem_rdata;
            stack_pointer_reg <= sp_up;
         end
         if (st_reg == ST_POP_SP && mem_ack) begin
            new_sp_reg <= mem_rdata;
            // The selector word sits one slot above the pointer word.
            stack_pointer_reg <= sp_up;
         end
         if (st_reg == ST_POP_SS && mem_ack) begin
            stack_selector_reg <= mem_rdata[15:0];
            stack_pointer_reg <= new_sp_reg + {48'h0000_0000_0000, ret_n};
            cur_pl_reg <= code_selector_reg[1:0];
            done <= 1'b1;
         end
      end
   end
   // ************************************************************
   // Checks
   // ************************************************************
   fault_no_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
      protection_fault |-> $stable(code_selector_reg)) else $error("fault changed code selector");
   order_tss_push_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_TSS_SS && mem_ack) |=> st_reg == ST_PUSH_SS) else $error("push order wrong");
   push_ss_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_reg == ST_PUSH_SS |-> mem_wdata[15:0] == h_ss_reg) else $error("wrong caller stack push");
   near_done_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_IDLE && start && cmd == PCR_CMD_NEAR) |=> done) else $error("near not done");
   direct_far_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_IDLE && start && cmd == PCR_CMD_DIRECT_FAR && long_mode)
      |=> protection_fault && st_reg == ST_IDLE) else $error("direct far accepted");
   fast_legacy_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_IDLE && start && cmd == PCR_CMD_FAST_ENTRY && !long_mode)
      |=> protection_fault) else $error("fast entry outside long mode");
   count_width_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_IDLE && start && addr_prefix) |=> count_mask_reg == PCR_MASK32)
      else $error("count width not reduced");
   target_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_PUSH_IP && mem_ack) |=> instr_pointer_reg == $past(g_off_reg))
      else $error("gate offset not taken");
   push_down_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_PUSH_CS && mem_ack && long_mode)
      |=> stack_pointer_reg == $past(stack_pointer_reg) - PCR_WORD8) else $error("push size");
   fault_keep_ss_a: assert property (@(posedge clk) disable iff (!rst_n)
      protection_fault |-> $stable(stack_selector_reg))
      else $error("fault changed stack selector");
   call_pl_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_PUSH_IP && mem_ack) |=> cur_pl_reg <= $past(cur_pl_reg))
      else $error("call lowered privilege");
   release_n_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_CHECK && ret_reg && chk_ok && long_mode)
      |=> stack_pointer_reg == $past(stack_pointer_reg) + {48'h0000_0000_0000, $past(ret_n)})
      else $error("release on privileged stack");
   pop_ss_slot_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg == ST_POP_SP && mem_ack && long_mode)
      |=> mem_addr == $past(mem_addr) + PCR_WORD8)
      else $error("selector popped from pointer slot");
   // ************************************************************
   // Covers
   // ************************************************************
   call_cov: cover property (@(posedge clk) st_reg == ST_PUSH_IP && mem_ack);
   copy_cov: cover property (@(posedge clk) st_reg == ST_CP_WR && mem_ack);
   ret_cov: cover property (@(posedge clk) st_reg == ST_POP_SS && mem_ack);
   fault_cov: cover property (@(posedge clk) protection_fault);
   same_pl_cov: cover property (@(posedge clk)
      st_reg == ST_CHECK && !ret_reg && chk_ok && !inward);
endmodule

/* bench/pcr_mem_model.sv */
/*
 Memory partner of the sequencer: one word store for stacks, gates and
 the task state segment. Assumes one request at a time, held until mem_ack.
*/
module pcr_mem_model
   import pcr_pkg::*;
(
   input wire logic clk,
   input wire logic [1:0] mem_op,
   input wire logic [63:0] mem_addr,
   input wire logic [63:0] mem_wdata,
   output logic [63:0] mem_rdata,
   output logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Store and answer
   // ****************
   logic [63:0] mem [logic [63:0]];
   logic [63:0] wr_a [$];
   logic [63:0] wr_d [$];
   int wait_cnt = 0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 64'h0000_0000_0000_0000;
   end
   // Read data toggles outside a read answer so that stale data never looks valid.
   always @(negedge clk) begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
         mem_ack <= 1'b0;
      end else if (mem_op != PCR_MEM_NONE && wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (mem_op == PCR_MEM_READ) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0000_0000_0000_0000;
         wait_cnt <= $urandom_range(3);
      end else if (mem_op == PCR_MEM_WRITE) begin
         mem_ack <= 1'b1;
         mem[mem_addr] = mem_wdata;
         wr_a.push_back(mem_addr);
         wr_d.push_back(mem_wdata);
         wait_cnt <= $urandom_range(3);
      end
   end
endmodule

/* bench/privilege_call_return_seq_tb.sv */
/*
 Self-checking bench of the sequencer against a reference state model.
 Assumes the memory partner above and the 25 MHz core clock.
*/
module privilege_call_return_seq_tb import pcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, start, long_mode, addr_prefix, mem_ack, fault, done, busy;
   logic [2:0] cmd;
   logic [15:0] instr_sel, ret_n, cs, ss, e_cs, e_ss, c_cs, c_ss;
   logic [63:0] instr_off, tss_base, mem_rdata, mem_addr, mem_wdata, ip, sp, cnt_mask;
   logic [63:0] e_ip, e_sp, c_ip, c_sp, goff;
   logic [31:0] disp;
   logic [1:0] mem_op, pl, e_pl;
   logic got_done, got_fault;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   pcr_seq pcr_seq_i (.clk(clk), .rst_n(rst_n), .start(start), .cmd(cmd),
      .long_mode(long_mode), .addr_prefix(addr_prefix), .instr_sel(instr_sel),
      .instr_off(instr_off), .disp(disp), .ret_n(ret_n), .tss_base(tss_base),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_op(mem_op), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .code_selector_reg(cs), .instr_pointer_reg(ip),
      .stack_selector_reg(ss), .stack_pointer_reg(sp), .cur_pl_reg(pl),
      .count_mask_reg(cnt_mask), .protection_fault(fault), .done(done), .busy(busy));
   pcr_mem_model pcr_mem_model_i (.clk(clk), .mem_op(mem_op), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // *************
   // Shared tasks
   // *************
   task automatic stop_test();
      $display("Counts: %0d mismatches in %0d checks", miscompares, check_count);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_state();
      chk(64'(cs), 64'(e_cs));
      chk(ip, e_ip);
      chk(64'(ss), 64'(e_ss));
      chk(sp, e_sp);
      chk(64'(pl), 64'(e_pl));
   endtask
   // Called just after a falling edge; start is dropped after the taking edge.
   // A refused command answers with the fault pulse alone, so either pulse ends the wait.
   task automatic run(input pcr_cmd_t c);
      int n = 0;
      cmd = c;
      start = 1'b1;
      @(posedge clk);
      #1;
      got_done = done;
      got_fault = fault;
      @(negedge clk);
      start = 1'b0;
      while (got_done !== 1'b1 && got_fault !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         got_done = done;
         got_fault = fault;
         n++;
      end
      chk(64'(got_done | got_fault), 64'h1);
   endtask
   function automatic logic [63:0] gate_w(input logic [15:0] tsel, input logic [4:0] cnt,
         input logic [1:0] dpl, input logic pres, input logic [31:0] off);
      return {off[31:16], pres, dpl, 1'b0, PCR_GATE_CALL32, 3'b000, cnt, tsel, off[15:0]};
   endfunction
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // A whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // *************
   // Main sequence
   // *************
   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      cmd = PCR_CMD_NONE;
      long_mode = 1'b1;
      addr_prefix = 1'b0;
      instr_sel = 16'h0000;
      instr_off = 64'h0000_0000_0000_0000;
      disp = 32'h0000_0000;
      ret_n = 16'h0000;
      tss_base = 64'h0000_0000_0000_1000;
      void'($urandom(54788));
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      chk(64'(pl), 64'h3);
      chk(cnt_mask, ~64'h0);
      {e_cs, e_ss, e_ip, e_sp, e_pl} = {16'h0, 16'h0, 64'h0, 64'h0, 2'h3};
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         long_mode = i[1];
         addr_prefix = i[0];
         disp = $urandom();
         run(PCR_CMD_NEAR);
         e_ip = e_ip + {{32{disp[31]}}, disp};
         e_ip = long_mode ? e_ip : (e_ip & PCR_MASK32);
         chk_state();
         if (long_mode) chk(cnt_mask, addr_prefix ? PCR_MASK32 : ~64'h0);
      end
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         long_mode = (i == 0);
         run(i == 0 ? PCR_CMD_DIRECT_FAR : (i == 1 ? PCR_CMD_FAST_ENTRY : PCR_CMD_FAST_EXIT));
         chk(64'(got_fault), 64'h1);
         chk_state();
      end
      goff = {$urandom(), $urandom()};
      pcr_mem_model_i.mem[64'd32] = gate_w(16'h0008, 5'd2, 2'h3, 1'b1, goff[31:0]);
      pcr_mem_model_i.mem[64'd40] = {32'h0, goff[63:32]};
      pcr_mem_model_i.mem[tss_base + 4] = 64'h0000_0000_0000_8000;
      pcr_mem_model_i.mem[tss_base + 12] = 64'h0000_0000_0000_0010;
      pcr_mem_model_i.mem[64'd80] = gate_w(16'h001B, 5'd0, 2'h3, 1'b1, goff[31:0]);
      pcr_mem_model_i.mem[64'd88] = {32'h0, goff[63:32]};
      @(negedge clk);
      long_mode = 1'b1;
      addr_prefix = 1'b0;
      instr_sel = 16'h002B;
      run(PCR_CMD_FAR_CALL);
      chk(64'(got_fault), 64'h0);
      {e_cs, e_ip, e_sp} = {16'h001B, goff, e_sp - 64'h10};
      chk_state();
      // The same-level call leaves a caller selector that carries level 3 for the return.
      pcr_mem_model_i.wr_a.delete();
      pcr_mem_model_i.wr_d.delete();
      @(negedge clk);
      instr_sel = 16'h0013;
      instr_off = {$urandom(), $urandom()};
      {c_cs, c_ss, c_ip, c_sp} = {e_cs, e_ss, e_ip, e_sp};
      run(PCR_CMD_FAR_CALL);
      chk(64'(got_fault), 64'h0);
      chk(64'(pcr_mem_model_i.wr_a.size()), 64'd6);
      chk(pcr_mem_model_i.wr_a[0], 64'h0000_0000_0000_7FF8);
      chk(pcr_mem_model_i.wr_d[0], 64'(c_ss));
      chk(pcr_mem_model_i.wr_d[1], c_sp);
      chk(pcr_mem_model_i.wr_d[2], pcr_mem_model_i.mem[c_sp + 64'h8]);
      chk(pcr_mem_model_i.wr_d[3], pcr_mem_model_i.mem[c_sp]);
      chk(pcr_mem_model_i.wr_d[4], 64'(c_cs));
      chk(pcr_mem_model_i.wr_d[5], c_ip);
      {e_cs, e_ss, e_ip, e_sp, e_pl} = {16'h0008, 16'h0010, goff, 64'h7FD0, 2'h0};
      chk_state();
      @(negedge clk);
      ret_n = 16'h0010;
      run(PCR_CMD_FAR_RET);
      chk(64'(got_fault), 64'h0);
      {e_cs, e_ss, e_ip, e_sp, e_pl} = {c_cs, c_ss, c_ip, c_sp + 64'h10, 2'h3};
      chk_state();
      for (int i = 0; i < 2; i++) begin
         pcr_mem_model_i.mem[64'(48 + 16 * i)] = gate_w(16'h0008, 5'd0, 2'(3 * i),
            1'(1 - i), goff[31:0]);
         @(negedge clk);
         instr_sel = 16'(8 * (i + 3) + 3);
         run(PCR_CMD_FAR_CALL);
         chk(64'(got_fault), 64'h1);
         chk_state();
      end
      stop_test();
   end
endmodule
